// >>> hdl/btt_pkg.sv
// package: constants, types and register map of the bus trace trigger sequencer
package btt_pkg;
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned TAG_LO_W    = 16;
  localparam int unsigned TAG_W       = 24;
  localparam int unsigned PROBE_W     = 8;
  localparam int unsigned CNT_W       = 16;
  localparam int unsigned ADDR_W      = 5;
  localparam int unsigned NTH_POST    = 4096;
  localparam int unsigned SYS_HZ      = 25000000;
  localparam int unsigned PROG_MIN_HZ = 50;
  localparam int unsigned PROG_MAX_HZ = 50000;
  localparam int unsigned OSC16_HZ    = 16000000;
  localparam int unsigned OSC8_HZ     = 8000000;
  localparam int unsigned OSC4_HZ     = 4000000;
  localparam int unsigned OSC2_HZ     = 2000000;
  localparam int unsigned OSC1_HZ     = 1000000;
  localparam int unsigned PHASE_W     = 32;
  // phase increment = hz * 2^32 / SYS_HZ
  localparam logic [63:0] PHASE_ONE   = 64'h0000_0001_0000_0000;

  // register indices (word addresses)
  localparam logic [ADDR_W-1:0] REG_EV_A   = 5'h00;
  localparam logic [ADDR_W-1:0] REG_EV_B   = 5'h01;
  localparam logic [ADDR_W-1:0] REG_EV_C   = 5'h02;
  localparam logic [ADDR_W-1:0] REG_EV_D   = 5'h03;
  localparam logic [ADDR_W-1:0] REG_MASK_A = 5'h04;
  localparam logic [ADDR_W-1:0] REG_MASK_B = 5'h05;
  localparam logic [ADDR_W-1:0] REG_MASK_C = 5'h06;
  localparam logic [ADDR_W-1:0] REG_MASK_D = 5'h07;
  localparam logic [ADDR_W-1:0] REG_MODE   = 5'h08;
  localparam logic [ADDR_W-1:0] REG_COUNT  = 5'h09;
  localparam logic [ADDR_W-1:0] REG_TAGCFG = 5'h0A;
  localparam logic [ADDR_W-1:0] REG_PROGHZ = 5'h0B;
  localparam logic [ADDR_W-1:0] REG_CMD    = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h0D;
  localparam logic [ADDR_W-1:0] REG_STORED = 5'h0E;
  localparam logic [ADDR_W-1:0] REG_ACHHZ  = 5'h0F;

  // mode register fields
  localparam int unsigned MODE_LSB   = 0;
  localparam int unsigned EN_LSB     = 4;
  localparam int unsigned RANGE_LSB  = 8;
  localparam int unsigned STOPEM_BIT = 12;
  // tag config fields
  localparam int unsigned TSRC_LSB   = 0;
  localparam int unsigned XBITS_BIT  = 4;
  // command bits
  localparam int unsigned CMD_ARM    = 0;
  localparam int unsigned CMD_DISARM = 1;
  localparam int unsigned CMD_STOP   = 2;

  typedef enum logic [3:0] {
    MODE_CONT_ALL, MODE_CONT_EV, MODE_CNT_ALL, MODE_CNT_EV,
    MODE_ANY, MODE_AB_CD, MODE_SEQ3, MODE_SEQ4, MODE_NTH
  } btt_mode_e;

  typedef enum logic [2:0] {
    TSRC_16M, TSRC_8M, TSRC_4M, TSRC_2M, TSRC_1M, TSRC_EXT, TSRC_PROG, TSRC_EMU
  } btt_tsrc_e;

  localparam logic [31:0] MODE_RST   = 32'h0000_0000;
  localparam logic [31:0] TAGCFG_RST = 32'h0000_0000;
  localparam logic [31:0] PROGHZ_RST = 32'h0000_03E8;

  typedef struct packed {
    logic              we;
    logic              re;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } btt_bus_s;

  typedef struct packed {
    logic [WORD_W-1:0]   word;
    logic [TAG_LO_W-1:0] tag;
    logic [PROBE_W-1:0]  extra;
    logic                trig;
    logic                wrap;
  } btt_frame_s;
endpackage

// >>> hdl/btt_sequencer.sv
// bus trace trigger sequencer: event match, trigger modes, time tag, frame output
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module btt_sequencer
  import btt_pkg::*;
#(
  parameter int unsigned NTH_POST_CYCLES = NTH_POST
) (
  // clock and reset
  input  wire logic                         SYS_CLK,
  input  wire logic                         RESET_N,
  // register port
  input  wire logic [btt_pkg::ADDR_W-1:0]   REG_ADDR,
  input  wire logic [31:0]                  REG_WDATA,
  input  wire logic                         REG_WR,
  input  wire logic                         REG_RD,
  output logic      [31:0]                  REG_RDATA,
  // observed bus
  input  wire logic                         BUS_CYCLE,
  input  wire logic [btt_pkg::WORD_W-1:0]   BUS_WORD,
  input  wire logic                         CPU_RUNNING,
  input  wire logic [btt_pkg::PROBE_W-1:0]  PROBE_DATA,
  input  wire logic                         TAG_EXTERNAL_CLOCK_INPUT,
  // trace output
  output logic                              FRAME_VALID,
  output btt_pkg::btt_frame_s               FRAME,
  output logic                              HALT_REQ
);
  import btt_pkg::*;

  // post length must fit the cycle counter
  if (NTH_POST_CYCLES < 1 || NTH_POST_CYCLES >= (1 << CNT_W)) begin : g_bad_post
    $error("NTH_POST_CYCLES out of range");
  end

  localparam int unsigned OSC_N = 5;
  localparam int unsigned OSC_HZ [OSC_N] = '{OSC16_HZ, OSC8_HZ, OSC4_HZ, OSC2_HZ, OSC1_HZ};

  // ---------------- registers
  logic [WORD_W-1:0] ev_r   [4];
  logic [WORD_W-1:0] mask_r [4];
  logic [31:0]       mode_r;
  logic [CNT_W-1:0]  count_r;
  logic [31:0]       tagcfg_r;
  logic [31:0]       proghz_r;
  logic [31:0]       rdata_r;

  wire btt_bus_s bus = '{we: REG_WR, re: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};
  wire btt_mode_e mode       = btt_mode_e'(mode_r[MODE_LSB +: 4]);
  wire [3:0]      ev_en      = mode_r[EN_LSB +: 4];
  wire [3:0]      range_en   = mode_r[RANGE_LSB +: 4];
  wire            stop_emu   = mode_r[STOPEM_BIT];
  wire btt_tsrc_e tsrc       = btt_tsrc_e'(tagcfg_r[TSRC_LSB +: 3]);
  wire            xbits      = tagcfg_r[XBITS_BIT];
  wire cmd_wr     = bus.we && bus.addr == REG_CMD;
  wire cmd_arm    = cmd_wr && bus.wdata[CMD_ARM];
  wire cmd_disarm = cmd_wr && bus.wdata[CMD_DISARM];
  wire cmd_stop   = cmd_wr && bus.wdata[CMD_STOP];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ev
      always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          ev_r[gi]   <= '0;
          mask_r[gi] <= '0;
        end else if (bus.we) begin
          if (bus.addr == REG_EV_A + ADDR_W'(gi)) ev_r[gi] <= bus.wdata;
          if (bus.addr == REG_MASK_A + ADDR_W'(gi)) mask_r[gi] <= bus.wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_r   <= MODE_RST;
      count_r  <= '0;
      tagcfg_r <= TAGCFG_RST;
      proghz_r <= PROGHZ_RST;
    end else if (bus.we) begin
      if (bus.addr == REG_MODE)   mode_r   <= bus.wdata;
      if (bus.addr == REG_COUNT)  count_r  <= bus.wdata[CNT_W-1:0];
      if (bus.addr == REG_TAGCFG) tagcfg_r <= bus.wdata;
      if (bus.addr == REG_PROGHZ) proghz_r <= bus.wdata;
    end
  end

  // ---------------- input synchronisers
  logic [2:0] cyc_s, run_s, ext_s;
  logic [WORD_W-1:0]  word_s1, word_s2;
  logic [PROBE_W-1:0] probe_s1, probe_s2;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cyc_s <= '0; run_s <= '0; ext_s <= '0;
      word_s1 <= '0; word_s2 <= '0; probe_s1 <= '0; probe_s2 <= '0;
    end else begin
      cyc_s <= {cyc_s[1:0], BUS_CYCLE};
      run_s <= {run_s[1:0], CPU_RUNNING};
      ext_s <= {ext_s[1:0], TAG_EXTERNAL_CLOCK_INPUT};
      word_s1 <= BUS_WORD;  word_s2 <= word_s1;
      probe_s1 <= PROBE_DATA; probe_s2 <= probe_s1;
    end
  end
  // word is held stable by the source around the strobe rising edge
  wire bus_tick = cyc_s[1] && !cyc_s[2];
  wire ext_tick = ext_s[1] && !ext_s[2];
  wire running  = run_s[1];

  // ---------------- event matching
  function automatic logic ev_hit(input logic [WORD_W-1:0] w, input logic [WORD_W-1:0] v,
                                  input logic [WORD_W-1:0] m);
    return ((w ^ v) & ~m) == '0;
  endfunction

  logic [3:0] hit;
  assign hit[0] = ev_en[0] && (ev_hit(word_s2, ev_r[0], mask_r[0]) ||
                  (range_en[1] && word_s2 >= ev_r[0] && word_s2 <= ev_r[1]));
  assign hit[1] = ev_en[1] && !range_en[1] && ev_hit(word_s2, ev_r[1], mask_r[1]);
  assign hit[2] = ev_en[2] && (range_en[2] ? (word_s2 >= ev_r[1] && word_s2 <= ev_r[2]) :
                  (ev_hit(word_s2, ev_r[2], mask_r[2]) ||
                   (range_en[3] && word_s2 >= ev_r[2] && word_s2 <= ev_r[3])));
  assign hit[3] = ev_en[3] && !range_en[3] && ev_hit(word_s2, ev_r[3], mask_r[3]);
  wire any_hit = |hit;

  // ---------------- programmable tag rate (nearest multiple of SYS_HZ/2^32)
  wire [31:0] prog_clamped = proghz_r < PROG_MIN_HZ ? 32'(PROG_MIN_HZ) :
                             proghz_r > PROG_MAX_HZ ? 32'(PROG_MAX_HZ) : proghz_r;
  wire [63:0] prog_inc_w = ({32'h0, prog_clamped} * PHASE_ONE + 64'(SYS_HZ / 2)) / 64'(SYS_HZ);
  wire [PHASE_W-1:0] prog_inc = prog_inc_w[PHASE_W-1:0];
  wire [63:0] ach_w = (64'(prog_inc) * 64'(SYS_HZ)) >> 32;
  wire [31:0] ach_hz = ach_w[31:0];

  function automatic logic [PHASE_W-1:0] osc_inc(input int unsigned hz);
    logic [63:0] t;
    t = (64'(hz) * PHASE_ONE) / 64'(SYS_HZ);
    return t[PHASE_W-1:0];
  endfunction

  logic [PHASE_W-1:0] phase_r;
  logic [PHASE_W-1:0] inc_sel;
  always_comb begin
    inc_sel = osc_inc(OSC_HZ[0]);
    case (tsrc)
      TSRC_16M:  inc_sel = osc_inc(OSC_HZ[0]);
      TSRC_8M:   inc_sel = osc_inc(OSC_HZ[1]);
      TSRC_4M:   inc_sel = osc_inc(OSC_HZ[2]);
      TSRC_2M:   inc_sel = osc_inc(OSC_HZ[3]);
      TSRC_1M:   inc_sel = osc_inc(OSC_HZ[4]);
      TSRC_PROG: inc_sel = prog_inc;
      default:   inc_sel = '0;
    endcase
  end
  wire [PHASE_W:0] phase_sum = {1'b0, phase_r} + {1'b0, inc_sel};
  wire div_tick = phase_sum[PHASE_W];
  wire tag_tick = tsrc == TSRC_EXT ? ext_tick :
                  tsrc == TSRC_EMU ? bus_tick :
                  div_tick;

  logic [TAG_W-1:0] tag_r;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase_r <= '0;
      tag_r   <= '0;
    end else begin
      phase_r <= phase_sum[PHASE_W-1:0];
      if (tag_tick) tag_r <= tag_r + TAG_W'(1);
    end
  end
  // rollover of the visible tag width on this tag tick
  wire tag_roll = tag_tick && (xbits ? &tag_r : &tag_r[TAG_LO_W-1:0]);

  // ---------------- sequencer
  typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_PRE, ST_POST, ST_DONE} btt_st_e;
  btt_st_e st_r, st_nxt;
  logic [1:0]       step_r, step_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             store;
  logic             halt_nxt;
  logic             halt_r;

  wire seq_mode  = mode == MODE_ANY || mode == MODE_AB_CD || mode == MODE_SEQ3 ||
                   mode == MODE_SEQ4;
  wire cnt_mode  = mode == MODE_CNT_ALL || mode == MODE_CNT_EV;
  wire ev_only   = mode == MODE_CONT_EV || mode == MODE_CNT_EV;
  // post length is the count in sequential modes; nth uses its fixed length
  wire [CNT_W-1:0] post_len = mode == MODE_NTH ? CNT_W'(NTH_POST_CYCLES) : count_r;

  logic trig_now;
  always_comb begin
    trig_now = 1'b0;
    step_nxt = step_r;
    case (mode)
      MODE_ANY:   trig_now = any_hit;
      MODE_AB_CD: begin
        if (step_r == 2'd0 && (hit[0] || hit[1])) step_nxt = 2'd1;
        if (step_r == 2'd1 && (hit[2] || hit[3])) trig_now = 1'b1;
      end
      MODE_SEQ3: begin
        if (hit[3] && ev_en[3]) step_nxt = 2'd0;
        else if (step_r == 2'd0 && hit[0]) step_nxt = 2'd1;
        else if (step_r == 2'd1 && hit[1]) step_nxt = 2'd2;
        else if (step_r == 2'd2 && hit[2]) trig_now = 1'b1;
      end
      MODE_SEQ4: begin
        if (step_r == 2'd0 && hit[0]) step_nxt = 2'd1;
        else if (step_r == 2'd1 && hit[1]) step_nxt = 2'd2;
        else if (step_r == 2'd2 && hit[2]) step_nxt = 2'd3;
        else if (step_r == 2'd3 && hit[3]) trig_now = 1'b1;
      end
      default: trig_now = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    store    = 1'b0;
    halt_nxt = halt_r;
    case (st_r)
      ST_IDLE:  if (cmd_arm) begin
        st_nxt   = ST_ARMED;
        cnt_nxt  = '0;
        halt_nxt = 1'b0;
      end
      ST_ARMED: if (running) st_nxt = ST_PRE;
      ST_PRE: if (bus_tick) begin
        if (mode == MODE_NTH) begin
          if (any_hit) begin
            store   = 1'b1;
            cnt_nxt = cnt_r + CNT_W'(1);
            if (cnt_r + CNT_W'(1) >= count_r) begin
              st_nxt  = ST_POST;
              cnt_nxt = '0;
            end
          end
        end else begin
          store = !ev_only || any_hit;
          if (cnt_mode && store) begin
            cnt_nxt = cnt_r + CNT_W'(1);
            if (cnt_r + CNT_W'(1) >= count_r) st_nxt = ST_DONE;
          end
          if (seq_mode && trig_now) begin
            st_nxt  = ST_POST;
            cnt_nxt = '0;
          end
        end
      end
      ST_POST: if (bus_tick) begin
        store   = 1'b1;
        cnt_nxt = cnt_r + CNT_W'(1);
        if (cnt_r + CNT_W'(1) >= post_len) st_nxt = ST_DONE;
      end
      ST_DONE: st_nxt = ST_DONE;
      default: st_nxt = ST_IDLE;
    endcase
    if ((st_r == ST_PRE || st_r == ST_POST) && !running && !bus_tick) st_nxt = ST_DONE;
    if (st_nxt == ST_DONE && st_r != ST_DONE && stop_emu && !cmd_disarm) halt_nxt = 1'b1;
    if (cmd_disarm) st_nxt = ST_IDLE;
    if (cmd_stop) begin
      st_nxt   = ST_IDLE;
      halt_nxt = 1'b1;
    end
    if (st_r == ST_DONE && cmd_arm) begin
      st_nxt   = ST_ARMED;
      cnt_nxt  = '0;
      halt_nxt = 1'b0;
    end
  end

  logic             post_trig_r;
  logic             fvalid_r;
  btt_frame_s       frame_r;
  logic             wrap_seen_r;
  logic [CNT_W-1:0] stored_r;
  wire step_clr = st_r != ST_PRE;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= ST_IDLE; step_r <= '0; cnt_r <= '0; halt_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      step_r <= step_clr ? 2'd0 : (bus_tick ? step_nxt : step_r);
      cnt_r  <= cnt_nxt;
      halt_r <= halt_nxt;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fvalid_r <= 1'b0; frame_r <= '0; wrap_seen_r <= 1'b0; stored_r <= '0;
    end else begin
      fvalid_r <= store;
      // rollover seen since last frame; a roll in the store cycle counts for next one
      wrap_seen_r <= store ? tag_roll : (wrap_seen_r || tag_roll);
      if (cmd_arm) stored_r <= '0;
      else if (store) stored_r <= stored_r + CNT_W'(1);
      if (store) begin
        frame_r.word  <= word_s2;
        frame_r.tag   <= tag_r[TAG_LO_W-1:0];
        frame_r.extra <= xbits ? tag_r[TAG_W-1:TAG_LO_W] : probe_s2;
        frame_r.trig  <= st_r == ST_POST && cnt_r == '0;
        frame_r.wrap  <= wrap_seen_r;
      end
    end
  end
  assign post_trig_r = st_r == ST_POST;

  // ---------------- read port
  wire [31:0] status_w = {19'h0, 4'(mode), halt_r, post_trig_r,
                          st_r == ST_DONE, st_r != ST_IDLE && st_r != ST_DONE,
                          st_r == ST_PRE || st_r == ST_POST, 2'(step_r), 2'h0};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (bus.addr)
      REG_EV_A, REG_EV_B, REG_EV_C, REG_EV_D:         rd_mux = ev_r[bus.addr[1:0]];
      REG_MASK_A, REG_MASK_B, REG_MASK_C, REG_MASK_D: rd_mux = mask_r[bus.addr[1:0]];
      REG_MODE:   rd_mux = mode_r;
      REG_COUNT:  rd_mux = 32'(count_r);
      REG_TAGCFG: rd_mux = tagcfg_r;
      REG_PROGHZ: rd_mux = proghz_r;
      REG_STATUS: rd_mux = status_w;
      REG_STORED: rd_mux = 32'(stored_r);
      REG_ACHHZ:  rd_mux = ach_hz;
      default:    rd_mux = '0;
    endcase
  end
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) rdata_r <= '0;
    else rdata_r <= bus.re ? rd_mux : '0;
  end

  assign REG_RDATA   = rdata_r;
  assign FRAME_VALID = fvalid_r;
  assign FRAME       = frame_r;
  assign HALT_REQ    = halt_r;

  // ---------------- checks
  chk_stop_halts: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    cmd_stop |=> HALT_REQ && st_r == ST_IDLE) else $error("stop did not halt");
  chk_disarm_nohalt: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    cmd_disarm && !cmd_stop && !halt_r |=> !HALT_REQ && st_r == ST_IDLE)
    else $error("disarm misbehaved");
  chk_arm_state: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    st_r == ST_IDLE && cmd_arm && !cmd_disarm && !cmd_stop |=> status_w[5])
    else $error("arm not reported");
  chk_done_halt: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    st_r != ST_DONE ##1 st_r == ST_DONE && stop_emu && $stable(mode_r) |-> HALT_REQ)
    else $error("no halt after recording");
  chk_frame_tag: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    store |=> FRAME_VALID && FRAME.tag == $past(tag_r[TAG_LO_W-1:0]))
    else $error("frame tag wrong");
  chk_extra_mux: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    store && !xbits |=> FRAME.extra == $past(probe_s2)) else $error("probe data lost");
  chk_seq3_reset: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    st_r == ST_PRE && mode == MODE_SEQ3 && bus_tick && hit[3] && !cmd_wr |=> step_r == 2'd0)
    else $error("D did not restart sequence");
  chk_post_len: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    st_r == ST_POST && bus_tick && !cmd_wr && running && cnt_r + CNT_W'(1) >= post_len
    |=> st_r == ST_DONE) else $error("post count overrun");
  chk_emu_tag: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    tsrc == TSRC_EMU && bus_tick && !bus.we |=> tag_r == $past(tag_r) + TAG_W'(1))
    else $error("emulator tag not advancing");
endmodule
`default_nettype wire

// >>> dv/btt_bus_model.sv
// emulated microcontroller bus: issues bus cycles and obeys halt
`timescale 1ns/1ns
`default_nettype none
module btt_bus_model
  import btt_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // bench control
  input  wire logic               go,
  input  wire logic [WORD_W-1:0]  word_in,
  output logic      [7:0]         taken,
  // device pins
  input  wire logic               halt_req,
  output logic                    cpu_running,
  output logic                    bus_cycle,
  output logic      [WORD_W-1:0]  bus_word,
  output logic      [PROBE_W-1:0] probe_data,
  output logic                    tag_ext_clk
);
  logic       run_r;
  logic [2:0] ph_r;
  logic [3:0] div_r;
  // a halted cpu still finishes the cycle it has begun
  assign cpu_running = run_r || (ph_r != 3'h0);
  assign bus_cycle   = ph_r[2];
  assign tag_ext_clk = div_r[2];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r      <= 1'b0;
      ph_r       <= 3'h0;
      div_r      <= 4'h0;
      taken      <= 8'h00;
      bus_word   <= '0;
      probe_data <= 8'h00;
    end else begin
      run_r <= go && !halt_req;
      div_r <= (div_r == 4'h4) ? 4'h0 : div_r + 4'h1;
      if (cpu_running) ph_r <= ph_r + 3'h1;
      if (run_r && ph_r == 3'h0) begin
        bus_word   <= word_in;
        probe_data <= word_in[7:0] ^ 8'hA5;
        taken      <= taken + 8'h01;
      end else if (!cpu_running) begin
        bus_word   <= ~bus_word;
        probe_data <= ~probe_data;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/test_bus_trace_trigger_sequencer.sv
// self-checking bench of the bus trace trigger sequencer
`timescale 1ns/1ns
`default_nettype none
module test_bus_trace_trigger_sequencer;
  import btt_pkg::*;
  localparam int unsigned NPOST = 8;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [ADDR_W-1:0]  addr = '0;
  logic [31:0]        wdata = '0;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic               go = 1'b0;
  logic [WORD_W-1:0]  word_in = '0;
  logic [31:0]        rdata;
  logic [7:0]         taken;
  logic               cpu_run, bus_cyc, ext_clk, fv, halt;
  logic [WORD_W-1:0]  bus_word;
  logic [PROBE_W-1:0] probe;
  btt_frame_s         frame;
  btt_frame_s         fq[$];
  logic [31:0]        wq[$];
  int                 miscompares = 0;
  int                 n_tests = 0;
  initial begin
    forever #20 clk = ~clk;
  end
  btt_sequencer #(.NTH_POST_CYCLES(NPOST)) dut (
    .SYS_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .BUS_CYCLE(bus_cyc),
    .BUS_WORD(bus_word), .CPU_RUNNING(cpu_run), .PROBE_DATA(probe),
    .TAG_EXTERNAL_CLOCK_INPUT(ext_clk), .FRAME_VALID(fv), .FRAME(frame),
    .HALT_REQ(halt)
  );
  btt_bus_model cpu (
    .clk(clk), .rst_n(rst_n), .go(go), .word_in(word_in), .taken(taken),
    .halt_req(halt), .cpu_running(cpu_run), .bus_cycle(bus_cyc),
    .bus_word(bus_word), .probe_data(probe), .tag_ext_clk(ext_clk)
  );
  always @(posedge clk) begin
    if (fv === 1'b1) fq.push_back(frame);
  end
  task automatic complete_run();
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // hands one word to the cpu and waits until it is on the bus
  task automatic feed(input logic [WORD_W-1:0] w);
    logic [7:0] t0;
    word_in <= w;
    t0 = taken;
    // a halted cpu takes no more words; the caller judges what was stored
    for (int i = 0; i < 40 && taken === t0 && halt !== 1'b1; i++) @(posedge clk);
    if (taken === t0 && halt !== 1'b1) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic set_ev(input logic [31:0] e [4]);
    for (int i = 0; i < 4; i++) reg_wr(REG_EV_A + ADDR_W'(i), e[i]);
  endtask
  task automatic arm(input logic [31:0] m, input logic [31:0] c, input logic [31:0] t);
    logic [31:0] st;
    fq.delete();
    reg_wr(REG_MODE, m);
    reg_wr(REG_COUNT, c);
    reg_wr(REG_TAGCFG, t);
    reg_wr(REG_CMD, 32'h1);
    reg_rd(REG_STATUS, st);
    chk({st[12:9], st[5], halt}, {m[3:0], 2'b10});
    go <= 1'b1;
  endtask
  task automatic capture(input logic [31:0] m, input logic [31:0] c, input logic [31:0] t);
    arm(m, c, t);
    foreach (wq[i]) feed(wq[i]);
    go <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
  task automatic s_reset();
    logic [31:0] d;
    logic [ADDR_W-1:0] a [5] = '{REG_MODE, REG_TAGCFG, REG_PROGHZ, REG_CMD, 5'h1F};
    logic [31:0] e [5] = '{32'h0, 32'h0, 32'h3E8, 32'h0, 32'h0};
    reg_wr(5'h1F, 32'hFFFF_FFFF);
    for (int i = 0; i < 5; i++) begin
      reg_rd(a[i], d);
      chk(d, e[i]);
    end
    for (int i = 0; i < 4; i++) reg_wr(REG_MASK_A + ADDR_W'(i), 32'h0);
  endtask
  task automatic s_seq3();
    logic [31:0] st;
    logic [15:0] dt;
    set_ev('{32'h1, 32'h2, 32'h3, 32'h4});
    wq = '{32'h1, 32'h2, 32'h4, 32'h3, 32'h1, 32'h2, 32'h3, 32'h9, 32'h9, 32'h9, 32'h9};
    capture(32'h0000_00F6, 32'h3, 32'h0);
    chk(fq.size(), 10);
    chk({fq[6].word[3:0], fq[6].trig, fq[7].trig}, 6'h0D);
    dt = fq[1].tag - fq[0].tag;
    chk(dt >= 16'h5 && dt <= 16'h6, 1'b1);
    reg_rd(REG_STATUS, st);
    chk({st[6], st[4]}, 2'b10);
    wq = '{32'h1, 32'h2, 32'h4, 32'h3, 32'h5, 32'h5, 32'h5, 32'h5};
    capture(32'h0000_0076, 32'h3, 32'h0);
    chk({8'(fq.size()), fq[4].trig}, {8'h07, 1'b1});
    wq = '{32'h2, 32'h1, 32'h3, 32'h2, 32'h4, 32'h3, 32'h4, 32'h5, 32'h5, 32'h5};
    capture(32'h0000_00F7, 32'h2, 32'h0);
    chk({8'(fq.size()), fq[6].trig, fq[7].trig}, {8'h09, 2'b01});
    wq = '{32'h3, 32'h2, 32'h5, 32'h4, 32'h5, 32'h5};
    capture(32'h0000_00F5, 32'h1, 32'h0);
    chk({8'(fq.size()), fq[3].trig, fq[4].trig}, {8'h05, 2'b01});
  endtask
  task automatic s_count();
    wq = '{32'h5, 32'h1, 32'h5, 32'h1, 32'h6, 32'h7, 32'h6, 32'h7, 32'h6, 32'h7, 32'h6, 32'h7, 32'h9};
    capture(32'h0000_0018, 32'h2, 32'h0);
    chk(fq.size(), 2 + NPOST);
    chk({fq[0].word[7:0], fq[1 + NPOST].word[7:0]}, 16'h0107);
    wq = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h5};
    capture(32'h0000_1002, 32'h4, 32'h0);
    chk({8'(fq.size()), halt}, {8'h04, 1'b1});
    capture(32'h0000_0000, 32'h2, 32'h0);
    chk(fq.size(), 5);
  endtask
  task automatic s_cmds();
    logic [31:0] st;
    arm(32'h0, 32'h0, 32'h0);
    feed(32'h1);
    feed(32'h2);
    reg_wr(REG_CMD, 32'h2);
    feed(32'h3);
    feed(32'h4);
    chk({8'(fq.size()), halt, cpu_run}, {8'h01, 2'b01});
    arm(32'h0, 32'h0, 32'h0);
    feed(32'h5);
    reg_wr(REG_CMD, 32'h4);
    reg_rd(REG_STATUS, st);
    chk({halt, st[4]}, 2'b10);
    go <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
  task automatic s_prog();
    logic [31:0] d;
    logic [31:0] rq [3] = '{32'h0A, 32'h3E8, 32'h1_86A0};
    logic [31:0] ex [3] = '{32'h32, 32'h3E8, 32'hC350};
    for (int i = 0; i < 3; i++) begin
      reg_wr(REG_PROGHZ, rq[i]);
      reg_rd(REG_ACHHZ, d);
      chk(d, ex[i]);
    end
  endtask
  task automatic s_tag();
    logic [15:0] dt;
    wq = '{32'h10, 32'h11, 32'h12, 32'h13};
    capture(32'h0, 32'h0, 32'h7);
    chk(16'(fq[2].tag - fq[1].tag), 32'h1);
    chk(fq[0].extra, 8'h10 ^ 8'hA5);
    capture(32'h0, 32'h0, 32'h17);
    chk(fq[0].extra, 8'h00);
    capture(32'h0, 32'h0, 32'h5);
    dt = fq[3].tag - fq[0].tag;
    chk(dt >= 16'h4 && dt <= 16'h5, 1'b1);
    chk({fq[0].wrap, fq[3].wrap}, 2'b00);
    set_ev('{32'h10, 32'h8000_0000, 32'hFFFF_FFF0, 32'hFFFF_FFF0});
    wq = '{32'h5, 32'h8000_0001, 32'h15, 32'h8000_0000, 32'h3};
    capture(32'h0000_0233, 32'h2, 32'h0);
    chk(fq.size(), 32'h2);
    chk(fq[0].word, 32'h15);
    chk(fq[1].word, 32'h8000_0000);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    s_reset();
    s_seq3();
    s_count();
    s_cmds();
    s_prog();
    s_tag();
    complete_run();
  end
endmodule
`default_nettype wire
